/* hdl/imb_interrupt_mask_bank.sv */
// Top of the interrupt mask bank with register port and request output
`timescale 1ns/1ns
module imb_interrupt_mask_bank (
  input wire logic mclk_i,
  input wire logic reset_n_i,
  input wire logic [15:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [15:0] charger_event_i,
  input wire logic [15:0] ldo_event_i,
  input wire logic [15:0] converter_event_i,
  input wire logic [15:0] gpio_event_i,
  output logic [15:0] rdata_o,
  output logic irq_o
);

  // ----------------------------------------
  // Bus capture
  // ----------------------------------------
  imb_pkg::imb_bus_type bus;
  assign bus = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};

  localparam int NUM = imb_pkg::NUM_GROUPS;
  localparam logic [15:0] GRP_VALID [NUM] = '{imb_pkg::VALID_CHG, imb_pkg::VALID_LDO,
    imb_pkg::VALID_CNV, imb_pkg::VALID_GPIO};
  localparam logic [15:0] STATUS_ADDR [NUM] = '{imb_pkg::ADDR_STATUS_CHG, imb_pkg::ADDR_STATUS_LDO,
    imb_pkg::ADDR_STATUS_CNV, imb_pkg::ADDR_STATUS_GPIO};
  localparam logic [15:0] MASK_ADDR [NUM] = '{imb_pkg::ADDR_MASK_CHG, imb_pkg::ADDR_MASK_LDO,
    imb_pkg::ADDR_MASK_CNV, imb_pkg::ADDR_MASK_GPIO};

  logic [15:0] group_event [NUM];
  logic [15:0] group_status [NUM];
  logic [15:0] group_mask [NUM];
  logic [NUM-1:0] group_pending;

  assign group_event[0] = charger_event_i;
  assign group_event[1] = ldo_event_i;
  assign group_event[2] = converter_event_i;
  assign group_event[3] = gpio_event_i;

  // ----------------------------------------
  // Event groups
  // ----------------------------------------
  genvar g;
  generate
    for (g = 0; g < NUM; g++) begin : gen_group
      imb_event_group #(
        .VALID(GRP_VALID[g])
      ) u_group (
        .mclk_i(mclk_i),
        .reset_n_i(reset_n_i),
        .event_i(group_event[g]),
        .status_clear_i(bus.wr && bus.addr == STATUS_ADDR[g]),
        .mask_write_i(bus.wr && bus.addr == MASK_ADDR[g]),
        .wdata_i(bus.wdata),
        .status_o(group_status[g]),
        .mask_o(group_mask[g]),
        .pending_o(group_pending[g])
      );
    end
  endgenerate

  // ----------------------------------------
  // Output gate and request
  // ----------------------------------------
  logic gate_reg;
  logic gate_next;
  logic irq_reg;
  logic irq_next;
  logic gate_write;

  assign gate_write = bus.wr && bus.addr == imb_pkg::ADDR_IRQ_CONFIG;

  always_comb begin
    gate_next = gate_reg;
    if (gate_write) begin
      gate_next = bus.wdata[imb_pkg::BIT_REQUEST_OUTPUT_GATE];
    end
    // Next gate value used so a gate write acts with no extra cycle
    irq_next = (|group_pending) && !gate_next;
  end

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      gate_reg <= imb_pkg::IRQ_GATE_RESET;
      irq_reg <= 1'b0;
    end else begin
      gate_reg <= gate_next;
      irq_reg <= irq_next;
    end
  end

  // ----------------------------------------
  // Write tally
  // ----------------------------------------
  logic [15:0] tally_reg;
  logic [15:0] tally_next;
  logic [15:0] lfsr_reg;
  logic [15:0] lfsr_next;
  logic time_write;

  assign time_write = bus.wr && (bus.addr == imb_pkg::ADDR_TIME_HI || bus.addr == imb_pkg::ADDR_TIME_LO);

  always_comb begin
    tally_next = tally_reg;
    // Free-running shifter; never reaches zero from a non-zero seed
    lfsr_next = lfsr_reg[0] ? ((lfsr_reg >> 1) ^ imb_pkg::LFSR_TAPS) : (lfsr_reg >> 1);
    if (time_write) begin
      tally_next = lfsr_reg;
    end
  end

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      tally_reg <= imb_pkg::TALLY_RESET;
      lfsr_reg <= imb_pkg::LFSR_SEED;
    end else begin
      tally_reg <= tally_next;
      lfsr_reg <= lfsr_next;
    end
  end

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  logic [15:0] rdata_reg;
  logic [15:0] rdata_next;

  always_comb begin
    // Read data stands in the cycle after each read cycle, zero otherwise
    rdata_next = 16'h0000;
    if (bus.rd) begin
      case (bus.addr)
        imb_pkg::ADDR_STATUS_CHG: rdata_next = group_status[0];
        imb_pkg::ADDR_STATUS_LDO: rdata_next = group_status[1];
        imb_pkg::ADDR_STATUS_CNV: rdata_next = group_status[2];
        imb_pkg::ADDR_STATUS_GPIO: rdata_next = group_status[3];
        imb_pkg::ADDR_MASK_CHG: rdata_next = group_mask[0];
        imb_pkg::ADDR_MASK_LDO: rdata_next = group_mask[1];
        imb_pkg::ADDR_MASK_CNV: rdata_next = group_mask[2];
        imb_pkg::ADDR_MASK_GPIO: rdata_next = group_mask[3];
        imb_pkg::ADDR_IRQ_CONFIG: rdata_next = {15'h0000, gate_reg};
        imb_pkg::ADDR_WRITE_TALLY: rdata_next = tally_reg;
        default: rdata_next = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rdata_reg <= 16'h0000;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  assign rdata_o = rdata_reg;
  assign irq_o = irq_reg;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  sequence s_time_write;
    bus.wr && (bus.addr == imb_pkg::ADDR_TIME_HI || bus.addr == imb_pkg::ADDR_TIME_LO);
  endsequence

  sequence s_pending_open;
    (|group_pending) && !gate_next;
  endsequence

  sequence s_request_high;
    irq_reg;
  endsequence

  sequence s_no_read;
    !bus.rd;
  endsequence

  sequence s_gate_write;
    gate_write;
  endsequence

  a_irq_follows_pending: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    ##1 (irq_reg == ((|$past(group_pending)) && !gate_reg)))
    else $error("request does not track pending");

  a_gate_blocks_irq: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    gate_reg |-> !irq_reg)
    else $error("request active while gated");

  a_mask_blocks: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    ((group_status[0] & ~group_mask[0]) == 16'h0000 && group_pending[3:1] == 3'b000) |-> !group_pending[0])
    else $error("masked event passes");

  a_tally_reload: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    s_time_write |=> (tally_reg == $past(lfsr_reg)))
    else $error("tally not reloaded");

  a_tally_holds: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    !(bus.wr && (bus.addr == imb_pkg::ADDR_TIME_HI || bus.addr == imb_pkg::ADDR_TIME_LO)) |=> $stable(tally_reg))
    else $error("tally moved without time write");

  a_mask_write_cnv: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    (bus.wr && bus.addr == imb_pkg::ADDR_MASK_CNV) |=> (group_mask[2] == ($past(bus.wdata) & imb_pkg::VALID_CNV)))
    else $error("converter mask write wrong");

  a_mask_write_gpio: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    (bus.wr && bus.addr == imb_pkg::ADDR_MASK_GPIO) |=> (group_mask[3] == ($past(bus.wdata) & imb_pkg::VALID_GPIO)))
    else $error("pin mask write wrong");

  a_mask_reset_ldo: assert property (@(posedge mclk_i)
    $rose(reset_n_i) |-> (group_mask[1] == imb_pkg::VALID_LDO && group_mask[0] == imb_pkg::VALID_CHG))
    else $error("mask reset value wrong");

  a_read_mask_chg: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    (bus.rd && bus.addr == imb_pkg::ADDR_MASK_CHG && !bus.wr) |=> (rdata_o == $past(group_mask[0])))
    else $error("charger mask readback wrong");

  a_mask_write_chg: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    (bus.wr && bus.addr == imb_pkg::ADDR_MASK_CHG) |=> (group_mask[0] == ($past(bus.wdata) & imb_pkg::VALID_CHG)))
    else $error("charger mask write wrong");

  a_mask_write_ldo: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    (bus.wr && bus.addr == imb_pkg::ADDR_MASK_LDO) |=> (group_mask[1] == ($past(bus.wdata) & imb_pkg::VALID_LDO)))
    else $error("regulator mask write wrong");

  a_mask_reset_rest: assert property (@(posedge mclk_i)
    $rose(reset_n_i) |-> (group_mask[2] == imb_pkg::VALID_CNV && group_mask[3] == imb_pkg::VALID_GPIO))
    else $error("mask reset value wrong");

  a_tally_reset: assert property (@(posedge mclk_i)
    $rose(reset_n_i) |-> (tally_reg == imb_pkg::TALLY_RESET))
    else $error("tally reset value wrong");

  a_irq_raised: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    s_pending_open |=> s_request_high)
    else $error("request missing while pending");

  a_gate_write_lands: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    s_gate_write |=> (gate_reg == $past(bus.wdata[imb_pkg::BIT_REQUEST_OUTPUT_GATE])))
    else $error("gate write wrong");

  a_rdata_idle: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    s_no_read |=> (rdata_o == 16'h0000))
    else $error("read data stands too long");

  a_read_tally: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    (bus.rd && bus.addr == imb_pkg::ADDR_WRITE_TALLY) |=> (rdata_o == $past(tally_reg)))
    else $error("tally readback wrong");

  a_read_status_ldo: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    (bus.rd && bus.addr == imb_pkg::ADDR_STATUS_LDO) |=> (rdata_o == $past(group_status[1])))
    else $error("status readback wrong");

  a_read_mask_gpio: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    (bus.rd && bus.addr == imb_pkg::ADDR_MASK_GPIO) |=> (rdata_o == $past(group_mask[3])))
    else $error("pin mask readback wrong");

  a_read_mask_cnv: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    (bus.rd && bus.addr == imb_pkg::ADDR_MASK_CNV) |=> (rdata_o == $past(group_mask[2])))
    else $error("converter mask readback wrong");

  a_read_mask_ldo: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    (bus.rd && bus.addr == imb_pkg::ADDR_MASK_LDO) |=> (rdata_o == $past(group_mask[1])))
    else $error("regulator mask readback wrong");

  a_read_gate: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    (bus.rd && bus.addr == imb_pkg::ADDR_IRQ_CONFIG) |=> (rdata_o == {15'h0000, $past(gate_reg)}))
    else $error("gate readback wrong");

  a_irq_reset_low: assert property (@(posedge mclk_i)
    $rose(reset_n_i) |-> !irq_reg)
    else $error("request high after reset");

  a_tally_nonzero: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    s_time_write |=> (tally_reg != 16'h0000))
    else $error("tally loaded with zero");

endmodule : imb_interrupt_mask_bank

/* hdl/imb_pkg.sv */
// Package of constants and types for the interrupt mask bank
// Functional notes
// - Mask one blocks event, zero passes it
// - All implemented mask bits reset to one, unimplemented bits to zero
// - Charger, sink, nvm, power-state masks at 401a
// - Regulator undervoltage masks bits 9..0 at 401b
// - Converter current and undervoltage masks at 401c
// - Pin event masks bits 11..0 at 401d
// - Write tally reloads random on time write
// - Status bit cleared by writing one
// - Output gate holds request inactive
package imb_pkg;

  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [15:0] ADDR_STATUS_CHG = 16'h4011;
  localparam logic [15:0] ADDR_STATUS_LDO = 16'h4012;
  localparam logic [15:0] ADDR_STATUS_CNV = 16'h4013;
  localparam logic [15:0] ADDR_STATUS_GPIO = 16'h4014;
  localparam logic [15:0] ADDR_IRQ_CONFIG = 16'h4017;
  localparam logic [15:0] ADDR_MASK_CHG = 16'h401a;
  localparam logic [15:0] ADDR_MASK_LDO = 16'h401b;
  localparam logic [15:0] ADDR_MASK_CNV = 16'h401c;
  localparam logic [15:0] ADDR_MASK_GPIO = 16'h401d;
  localparam logic [15:0] ADDR_WRITE_TALLY = 16'h4020;
  localparam logic [15:0] ADDR_TIME_HI = 16'h4021;
  localparam logic [15:0] ADDR_TIME_LO = 16'h4022;

  // ----------------------------------------
  // Implemented bits per group
  // ----------------------------------------
  localparam int NUM_GROUPS = 4;
  localparam logic [15:0] VALID_CHG = 16'hfff7;
  localparam logic [15:0] VALID_LDO = 16'h03ff;
  localparam logic [15:0] VALID_CNV = 16'h030f;
  localparam logic [15:0] VALID_GPIO = 16'h0fff;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int BIT_REQUEST_OUTPUT_GATE = 0;
  localparam int BIT_MASK_BATTERY_HOT = 15;
  localparam int BIT_MASK_ON_WAKE_EVENT = 0;

  // ----------------------------------------
  // Reset values and shifter taps
  // ----------------------------------------
  localparam logic [15:0] TALLY_RESET = 16'h0000;
  localparam logic [15:0] LFSR_SEED = 16'hace1;
  localparam logic [15:0] LFSR_TAPS = 16'hb400;
  localparam logic [15:0] STATUS_RESET = 16'h0000;
  localparam logic IRQ_GATE_RESET = 1'b0;

  typedef struct packed {
    logic [15:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } imb_bus_type;

endpackage : imb_pkg

/* hdl/imb_event_group.sv */
// One group of latched events with its mask register
`timescale 1ns/1ns
module imb_event_group #(
  parameter logic [15:0] VALID = 16'hffff
) (
  input wire logic mclk_i,
  input wire logic reset_n_i,
  input wire logic [15:0] event_i,
  input wire logic status_clear_i,
  input wire logic mask_write_i,
  input wire logic [15:0] wdata_i,
  output logic [15:0] status_o,
  output logic [15:0] mask_o,
  output logic pending_o
);

  logic [15:0] status_reg;
  logic [15:0] status_next;
  logic [15:0] mask_reg;
  logic [15:0] mask_next;

  always_comb begin
    status_next = status_reg;
    mask_next = mask_reg;
    if (status_clear_i) begin
      status_next = status_next & ~wdata_i;
    end
    status_next = (status_next | event_i) & VALID;
    if (mask_write_i) begin
      mask_next = wdata_i & VALID;
    end
  end

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      status_reg <= imb_pkg::STATUS_RESET;
      mask_reg <= VALID;
    end else begin
      status_reg <= status_next;
      mask_reg <= mask_next;
    end
  end

  assign status_o = status_reg;
  assign mask_o = mask_reg;
  assign pending_o = |(status_reg & ~mask_reg);

  a_event_set_wins: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    (|(event_i & VALID)) |=> ((status_reg & $past(event_i) & VALID) == ($past(event_i) & VALID)))
    else $error("event lost on clear");

  a_clear_one_only: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    (status_clear_i && event_i == 16'h0000) |=> (status_reg == ($past(status_reg) & ~$past(wdata_i))))
    else $error("status clear wrong");

endmodule : imb_event_group

/* testbench/imb_host_model.sv */
// Host side model that counts interrupt requests
`timescale 1ns/1ns
module imb_host_model (
  input wire logic mclk_i,
  input wire logic reset_n_i,
  input wire logic irq_i,
  output logic [7:0] irq_seen_o
);
  logic irq_reg;
  logic [7:0] seen_next;

  always_comb begin
    seen_next = irq_seen_o;
    // Host notices each new request level once
    if (irq_i && !irq_reg) begin
      seen_next = irq_seen_o + 8'h01;
    end
  end

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      irq_reg <= 1'b0;
      irq_seen_o <= 8'h00;
    end else begin
      irq_reg <= irq_i;
      irq_seen_o <= seen_next;
    end
  end
endmodule : imb_host_model

/* testbench/testbench.sv */
// Self-checking bench for the interrupt mask bank
`timescale 1ns/1ns
module testbench;
  localparam logic [15:0] MADR [4] = '{imb_pkg::ADDR_MASK_CHG, imb_pkg::ADDR_MASK_LDO,
    imb_pkg::ADDR_MASK_CNV, imb_pkg::ADDR_MASK_GPIO};
  localparam logic [15:0] SADR [4] = '{imb_pkg::ADDR_STATUS_CHG, imb_pkg::ADDR_STATUS_LDO,
    imb_pkg::ADDR_STATUS_CNV, imb_pkg::ADDR_STATUS_GPIO};
  localparam logic [15:0] VLD [4] = '{imb_pkg::VALID_CHG, imb_pkg::VALID_LDO,
    imb_pkg::VALID_CNV, imb_pkg::VALID_GPIO};
  logic mclk, reset_n, wr, rd, irq;
  logic [15:0] addr, wdata, rdata, v, w, t0;
  logic [15:0] ev [4];
  logic [7:0] seen;
  int err_total, n_compared, g, b;

  imb_interrupt_mask_bank DUT (.mclk_i(mclk), .reset_n_i(reset_n), .addr_i(addr), .wdata_i(wdata),
    .wr_i(wr), .rd_i(rd), .charger_event_i(ev[0]), .ldo_event_i(ev[1]), .converter_event_i(ev[2]),
    .gpio_event_i(ev[3]), .rdata_o(rdata), .irq_o(irq));
  imb_host_model host (.mclk_i(mclk), .reset_n_i(reset_n), .irq_i(irq), .irq_seen_o(seen));

  task chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task wr_reg(input logic [15:0] a, input logic [15:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
    repeat (2) @(posedge mclk);
    #1;
  endtask : wr_reg

  task rd_reg(input logic [15:0] a, output logic [15:0] d);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask : rd_reg

  task pulse(input int gi, input logic [15:0] bits);
    @(posedge mclk);
    ev[gi] <= bits;
    @(posedge mclk);
    ev[gi] <= 16'h0000;
    repeat (2) @(posedge mclk);
    #1;
  endtask : pulse

  task test_done();
    $display("compared %0d mismatched %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : test_done

  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  initial begin
    #200000;
    err_total++;
    test_done();
  end

  initial begin
    reset_n = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    addr = 16'h0000;
    wdata = 16'h0000;
    ev = '{default: 16'h0000};
    err_total = 0;
    n_compared = 0;
    void'($urandom(94947));
    repeat (12) @(posedge mclk);
    reset_n <= 1'b1;
    for (g = 0; g < 4; g++) begin
      rd_reg(MADR[g], v);
      chk(v, VLD[g]);
    end
    wr_reg(imb_pkg::ADDR_WRITE_TALLY, 16'hffff);
    rd_reg(imb_pkg::ADDR_WRITE_TALLY, t0);
    chk(t0, imb_pkg::TALLY_RESET);
    rd_reg(16'h401e, v);
    chk(v, 16'h0000);
    $display("test reset values done");
    for (g = 0; g < 4; g++) begin
      w = 16'($urandom);
      wr_reg(MADR[g], w);
      rd_reg(MADR[g], v);
      chk(v, w & VLD[g]);
    end
    $display("test mask access done");
    for (g = 0; g < 4; g++) begin
      do b = $urandom_range(15, 0); while (!VLD[g][b]);
      wr_reg(MADR[g], 16'hffff);
      pulse(g, 16'h0001 << b);
      chk({15'h0, irq}, 16'h0000);
      rd_reg(SADR[g], v);
      chk(v, 16'h0001 << b);
      wr_reg(MADR[g], ~(16'h0001 << b));
      chk({15'h0, irq}, 16'h0001);
      wr_reg(imb_pkg::ADDR_IRQ_CONFIG, 16'h0001);
      chk({15'h0, irq}, 16'h0000);
      wr_reg(imb_pkg::ADDR_IRQ_CONFIG, 16'h0000);
      wr_reg(SADR[g], ~(16'h0001 << b));
      chk({15'h0, irq}, 16'h0001);
      wr_reg(SADR[g], 16'h0001 << b);
      chk({15'h0, irq}, 16'h0000);
      rd_reg(SADR[g], v);
      chk(v, 16'h0000);
      chk({8'h00, seen}, 16'(2 * g + 2));
    end
    $display("test masking done");
    wr_reg(imb_pkg::ADDR_TIME_LO, 16'($urandom));
    rd_reg(imb_pkg::ADDR_WRITE_TALLY, v);
    chk({15'h0, v !== t0}, 16'h0001);
    t0 = v;
    wr_reg(imb_pkg::ADDR_TIME_HI, 16'($urandom));
    rd_reg(imb_pkg::ADDR_WRITE_TALLY, v);
    chk({15'h0, v !== t0}, 16'h0001);
    $display("test write tally done");
    test_done();
  end
endmodule : testbench
